// *** rtl/scprt_pkg.sv ***
package scprt_pkg;
   // Register bus geometry
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   // Register offsets
   localparam logic [3:0]  TRIM_OFFSET     = 4'h0;
   localparam logic [3:0]  PRESCALE_OFFSET = 4'h1;
   // Prescale register fields and the trim range bit
   localparam int          UNLOCK_BIT      = 7;
   localparam int          CODE_W          = 4;
   localparam logic [7:0]  UNLOCK_PATTERN  = 8'h80;
   localparam logic [7:0]  PRESCALE_MASK   = 8'h8F;
   localparam int          TRIM_RANGE_BIT  = 7;
   // Values after reset, and the largest division code
   localparam logic [3:0]  CODE_RESET_FAST = 4'h0;
   localparam logic [3:0]  CODE_RESET_DIV8 = 4'h3;
   localparam logic [3:0]  CODE_MAX        = 4'h8;
   localparam logic [7:0]  TRIM_RESET      = 8'h00;
   // Window cycle count and divider counter width
   localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
   localparam int          DIV_CNT_W       = 8;

   // Start-up sequencing
   typedef enum logic [1:0] {SYNC_A, SYNC_B, LOAD, RUN} scprt_init_e;

   // Terminal count mask for a division code; reserved codes act as the largest
   function automatic logic [7:0] divMask(input logic [3:0] code);
      logic [3:0] eff;
      eff = (code > CODE_MAX) ? CODE_MAX : code;
      divMask = 8'(9'h001 << eff) - 8'h01;
   endfunction
endpackage

// *** rtl/scprt_div_if.sv ***
`timescale 1ns/100ps
// Control path between register logic and the divider
interface scprt_div_if;
   logic       run;        // Divider allowed to count
   logic       codeLoad;   // One-cycle pulse carrying a new code
   logic [3:0] codeValue;  // Code that goes with codeLoad
   logic       tick;       // System clock enable pulse
   logic [3:0] activeCode; // Code now in force

   modport ctrl (output run, output codeLoad, output codeValue,
                 input tick, input activeCode);
   modport div  (input run, input codeLoad, input codeValue,
                 output tick, output activeCode);
endinterface

// *** rtl/scprt_divider.sv ***
`timescale 1ns/100ps
// Power-of-two divider counted at the undivided rate
module scprt_divider #(
   parameter int CNT_W = scprt_pkg::DIV_CNT_W
) (
   input wire logic core_clk,
   input wire logic resetn,
   scprt_div_if.div divPort
);
   if (CNT_W < 8) begin : g_chk
      $error("scprt_divider: CNT_W must be at least 8");
   end

   logic [CNT_W-1:0] cnt_reg,    cnt_next;    // Count within one period
   logic             tick_reg,   tick_next;   // Enable pulse
   logic [3:0]       active_reg, active_next; // Code in force
   logic [3:0]       pcode_reg,  pcode_next;  // Code waiting for a boundary
   logic             pend_reg,   pend_next;   // A code is waiting

   // Next state: count, tick at terminal count, switch on a boundary while running
   always_comb begin
      cnt_next    = cnt_reg;
      tick_next   = 1'b0;
      active_next = active_reg;
      pcode_next  = pcode_reg;
      pend_next   = pend_reg;
      if (!divPort.run) begin
         // Held idle: a code loads at once
         cnt_next  = '0;
         pend_next = 1'b0;
         if (divPort.codeLoad) begin
            active_next = divPort.codeValue;
         end
      end else begin
         if (divPort.codeLoad) begin
            pend_next  = 1'b1;
            pcode_next = divPort.codeValue;
         end
         // Counter clocked at the source rate
         if (cnt_reg == CNT_W'(scprt_pkg::divMask(active_reg))) begin
            tick_next = 1'b1;
            cnt_next  = '0;
            // Old period completes before the new one starts
            if (pend_next) begin
               active_next = pcode_next;
               pend_next   = 1'b0;
            end
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   // State registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg    <= '0;
         tick_reg   <= 1'b0;
         active_reg <= scprt_pkg::CODE_RESET_FAST;
         pcode_reg  <= scprt_pkg::CODE_RESET_FAST;
         pend_reg   <= 1'b0;
      end else begin
         cnt_reg    <= cnt_next;
         tick_reg   <= tick_next;
         active_reg <= active_next;
         pcode_reg  <= pcode_next;
         pend_reg   <= pend_next;
      end
   end

   assign divPort.tick       = tick_reg;
   assign divPort.activeCode = active_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_switch_on_edge: assert property (
      divPort.run && $past(divPort.run) && $changed(active_reg) |-> tick_reg)
      else $error("Division changed away from a period boundary");
   chk_no_fast_pulse: assert property (
      tick_reg && active_reg != 4'h0 |=> !tick_reg)
      else $error("Back-to-back enable with a dividing code");
endmodule

// *** rtl/scprt_unlock.sv ***
`timescale 1ns/100ps
// Timed change-enable window
module scprt_unlock (
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic unlockReq,
   input  wire logic codeAccept,
   output wire logic windowOpen
);
   logic [2:0] cnt_reg, cnt_next; // Cycles left in the window

   // Next window count
   always_comb begin
      cnt_next = cnt_reg;
      if (codeAccept) begin
         // Code written: close early
         cnt_next = 3'h0;
      end else if (unlockReq && cnt_reg == 3'h0) begin
         // Open only when closed, so no restart
         cnt_next = scprt_pkg::UNLOCK_CYCLES;
      end else if (cnt_reg != 3'h0) begin
         // Count down to timeout
         cnt_next = cnt_reg - 3'h1;
      end
   end

   // Window register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign windowOpen = (cnt_reg != 3'h0);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_window_limit: assert property (
      windowOpen [*4] |=> !windowOpen)
      else $error("Change window open longer than four cycles");
endmodule

// *** rtl/scprt_clock_ctrl.sv ***
// Overview of operation
// - Division switch glitch-free, never faster than both
// - Divider counts at source rate, count hidden
// - New rate within old plus one-two new
// - Reset loads factory trim value
// - Trim register writable, readable, drives oscillator
// - Top trim bit picks oscillator range
// - Low trim bits tune monotonically
// - Change-enable sets only on clean write
// - Change-enable clears after four cycles
// - Rewriting change-enable neither extends nor clears
// - Division code sets system clock ratio
// - Reset code follows divide-by-eight fuse
// - Any code accepted through protected sequence
// - Codes divide by powers of two
// - Divided clock feeds all synchronous domains
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
module scprt_clock_ctrl (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output wire logic [7:0] regRdata,
   input  wire logic       divideByEightFuse,
   input  wire logic [7:0] factoryTrim,
   output wire logic       sysClkEn,
   output wire logic [7:0] oscTrim,
   output wire logic       trimRangeSelect,
   output wire logic [3:0] activeDivCode
);
   ////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////

   // Strap synchronisers, first and second stage
   logic       fuseS1_reg;
   logic       fuseS2_reg;
   logic [7:0] factS1_reg;
   logic [7:0] factS2_reg;

   // Start-up state
   scprt_pkg::scprt_init_e state_reg, state_next;

   // Software-visible registers
   logic [7:0] trim_reg,  trim_next;  // Oscillator trim
   logic [3:0] code_reg,  code_next;  // Division code
   logic [7:0] rdata_reg, rdata_next; // Read data

   // Decoded bus events
   logic       running;     // Start-up done
   logic       hitTrim;     // Access to trim
   logic       hitPre;      // Access to prescale
   logic       unlockReq;   // Clean change-enable write
   logic       codeAccept;  // Code write inside window
   logic       windowOpen;  // Change-enable bit
   logic       codeLoad;    // Pulse to divider
   logic [3:0] loadValue;   // Code sent with the pulse

   // Divider link
   scprt_div_if divLink ();

   ////////////////////////////////////////////////////////////////
   // Strap capture
   ////////////////////////////////////////////////////////////////

   // Two flip-flops on the fuse and factory value pins
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fuseS1_reg <= 1'b0;
         fuseS2_reg <= 1'b0;
         factS1_reg <= scprt_pkg::TRIM_RESET;
         factS2_reg <= scprt_pkg::TRIM_RESET;
      end else begin
         fuseS1_reg <= divideByEightFuse;
         fuseS2_reg <= fuseS1_reg;
         factS1_reg <= factoryTrim;
         factS2_reg <= factS1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Start-up sequencer
   ////////////////////////////////////////////////////////////////

   // Wait for the synchronisers, load once, then run
   always_comb begin
      case (state_reg)
         scprt_pkg::SYNC_A: begin
            state_next = scprt_pkg::SYNC_B;
         end
         scprt_pkg::SYNC_B: begin
            state_next = scprt_pkg::LOAD;
         end
         scprt_pkg::LOAD: begin
            state_next = scprt_pkg::RUN;
         end
         scprt_pkg::RUN: begin
            state_next = scprt_pkg::RUN;
         end
         default: begin
            state_next = scprt_pkg::SYNC_A;
         end
      endcase
   end

   // Sequencer register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= scprt_pkg::SYNC_A;
      end else begin
         state_reg <= state_next;
      end
   end

   assign running = (state_reg == scprt_pkg::RUN);

   ////////////////////////////////////////////////////////////////
   // Bus decode
   ////////////////////////////////////////////////////////////////

   // Address match
   assign hitTrim = (regAddr == scprt_pkg::TRIM_OFFSET);
   assign hitPre  = (regAddr == scprt_pkg::PRESCALE_OFFSET);

   // Unlock only when every other bit is zero
   assign unlockReq = running && regWr && hitPre
                      && (regWdata == scprt_pkg::UNLOCK_PATTERN);

   // Code taken with change-enable zero inside the window
   assign codeAccept = running && regWr && hitPre && windowOpen
                       && !regWdata[scprt_pkg::UNLOCK_BIT];

   // Change-enable window
   scprt_unlock u_unlock (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .unlockReq  (unlockReq),
      .codeAccept (codeAccept),
      .windowOpen (windowOpen)
   );

   ////////////////////////////////////////////////////////////////
   // Register file
   ////////////////////////////////////////////////////////////////

   // Next values of trim, code and read data
   always_comb begin
      trim_next  = trim_reg;
      code_next  = code_reg;
      rdata_next = 8'h00;
      if (state_reg == scprt_pkg::LOAD) begin
         // Factory trim loaded during start-up
         trim_next = factS2_reg;
         // Reset code from the fuse
         code_next = fuseS2_reg ? scprt_pkg::CODE_RESET_DIV8
                                : scprt_pkg::CODE_RESET_FAST;
      end else if (running && regWr && hitTrim) begin
         // Software trim write reaches the oscillator
         trim_next = regWdata;
      end else if (codeAccept) begin
         // Any code kept as written
         code_next = regWdata[3:0];
      end
      if (regRd) begin
         if (hitTrim) begin
            // Trim readback
            rdata_next = trim_reg;
         end else if (hitPre) begin
            // Unused bits read zero
            rdata_next = {windowOpen, 3'h0, code_reg}
                         & scprt_pkg::PRESCALE_MASK;
         end else begin
            // Unmapped reads return zero
            rdata_next = 8'h00;
         end
      end
   end

   // Register file flops
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         trim_reg  <= scprt_pkg::TRIM_RESET;
         code_reg  <= scprt_pkg::CODE_RESET_FAST;
         rdata_reg <= 8'h00;
      end else begin
         trim_reg  <= trim_next;
         code_reg  <= code_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Divider control
   ////////////////////////////////////////////////////////////////

   // Start-up load goes in directly, later codes via the boundary
   assign codeLoad  = (state_reg == scprt_pkg::LOAD) || codeAccept;
   assign loadValue = code_next;

   // Code drives the ratio
   assign divLink.run       = running;
   assign divLink.codeLoad  = codeLoad;
   assign divLink.codeValue = loadValue;

   // Divider instance
   scprt_divider #(
      .CNT_W (scprt_pkg::DIV_CNT_W)
   ) u_divider (
      .core_clk (core_clk),
      .resetn   (resetn),
      .divPort  (divLink)
   );

   ////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////

   // Enable for CPU, flash, I/O and converter domains
   assign sysClkEn        = divLink.tick;
   // Range bit and tuning bits to the oscillator
   assign oscTrim         = trim_reg;
   assign trimRangeSelect = trim_reg[scprt_pkg::TRIM_RANGE_BIT];
   assign activeDivCode   = divLink.activeCode;
   assign regRdata        = rdata_reg;

   ////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // Clean unlock write
   sequence seqUnlock;
      running && regWr && hitPre && !windowOpen
      && regWdata == scprt_pkg::UNLOCK_PATTERN;
   endsequence

   // Code write inside the window
   sequence seqCodeWrite;
      codeAccept;
   endsequence

   chk_unlock_opens: assert property (
      seqUnlock |=> windowOpen)
      else $error("Clean unlock write did not open the window");

   chk_dirty_ignored: assert property (
      running && regWr && hitPre && !windowOpen
      && regWdata != scprt_pkg::UNLOCK_PATTERN |=> !windowOpen)
      else $error("Unclean write opened the window");

   chk_rewrite_kept: assert property (
      seqUnlock ##[1:3] (windowOpen && unlockReq) |=> windowOpen)
      else $error("Rewrite of change-enable cleared it");

   chk_code_closes: assert property (
      seqCodeWrite |=> !windowOpen)
      else $error("Code write left the window open");

   chk_window_holds: assert property (
      seqUnlock ##1 (!codeAccept) [*3] |=> windowOpen)
      else $error("Change window closed before four cycles");

   chk_code_taken: assert property (
      seqUnlock ##[1:4] seqCodeWrite |=> code_reg == $past(regWdata[3:0]))
      else $error("Protected code write not stored");

   chk_code_locked: assert property (
      running && regWr && hitPre && !windowOpen |=> $stable(code_reg))
      else $error("Code changed without unlock");

   chk_new_rate: assert property (
      seqCodeWrite |=> ##[0:255] (sysClkEn && activeDivCode == code_reg))
      else $error("New division not in force at next boundary");

   chk_reserved_zero: assert property (
      regRd && hitPre |=> regRdata[6:4] == 3'h0 && regRdata[3:0] == $past(code_reg)
                          && regRdata[7] == $past(windowOpen))
      else $error("Prescale readback wrong or unused bits nonzero");

   chk_read_idle: assert property (
      !regRd |=> regRdata == 8'h00)
      else $error("Read data present without a read");

   chk_trim_write: assert property (
      running && regWr && hitTrim |=> oscTrim == $past(regWdata))
      else $error("Trim write not applied");

   chk_reset_code: assert property (
      state_reg == scprt_pkg::LOAD |=> code_reg ==
         ($past(fuseS2_reg) ? scprt_pkg::CODE_RESET_DIV8
                            : scprt_pkg::CODE_RESET_FAST))
      else $error("Reset code does not follow the fuse");

   chk_factory_trim: assert property (
      state_reg == scprt_pkg::LOAD |=> oscTrim == $past(factS2_reg))
      else $error("Factory trim not loaded");
endmodule

// *** verification/scprt_clock_ctrl_bench.sv ***
`timescale 1ns/100ps
module scprt_clock_ctrl_bench;
   ////////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic       core_clk          = 1'b0;  // 250 MHz core clock
   logic       resetn            = 1'b0;  // Active low reset
   logic [3:0] regAddr           = 4'h0;  // Register address
   logic [7:0] regWdata          = 8'h00; // Write data
   logic       regWr             = 1'b0;  // Write strobe
   logic       regRd             = 1'b0;  // Read strobe
   logic [7:0] regRdata;                  // Read data
   logic       divideByEightFuse = 1'b0;  // Fuse strap
   logic [7:0] factoryTrim       = 8'h00; // Factory trim strap
   logic       sysClkEn;                  // Divided clock enable
   logic [7:0] oscTrim;                   // Trim to oscillator
   logic       trimRangeSelect;           // Oscillator range
   logic [3:0] activeDivCode;             // Code in force
   int         errCount          = 0;     // Mismatches seen
   int         nCompared         = 0;     // Comparisons made
   int         curP              = 1;     // Divided period now expected
   logic [7:0] trimVals [4]      = '{8'h7F, 8'h80, 8'h00, 8'hFF}; // Trim cases
   logic [3:0] codes [11]        = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                                     4'h7, 4'h8, 4'h9, 4'hF, 4'h0}; // Code cases

   ////////////////////////////////////////////////////////////////////////////
   // Clock generation: 4 ns period
   always #2 core_clk = ~core_clk;

   // Device under test
   scprt_clock_ctrl dut_u (
      .core_clk          (core_clk),
      .resetn            (resetn),
      .regAddr           (regAddr),
      .regWdata          (regWdata),
      .regWr             (regWr),
      .regRd             (regRd),
      .regRdata          (regRdata),
      .divideByEightFuse (divideByEightFuse),
      .factoryTrim       (factoryTrim),
      .sysClkEn          (sysClkEn),
      .oscTrim           (oscTrim),
      .trimRangeSelect   (trimRangeSelect),
      .activeDivCode     (activeDivCode)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic stopTest();
      if (errCount == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Compare one value and count it
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Reset with given straps; outputs checked while reset holds
   task automatic doReset(input logic fuse, input logic [7:0] trim);
      @(posedge core_clk);
      resetn            <= 1'b0;
      regWr             <= 1'b0;
      regRd             <= 1'b0;
      divideByEightFuse <= fuse;
      factoryTrim       <= trim;
      repeat (3) @(posedge core_clk);
      chk({7'h00, sysClkEn, oscTrim}, 16'h0000);
      resetn <= 1'b1;
      curP = fuse ? 8 : 1;
      repeat (3) @(posedge core_clk);
   endtask

   // One-cycle write; strobe stays up for a following call
   task automatic wrReg(input logic [3:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      regAddr  <= addr;
      regWdata <= data;
      regWr    <= 1'b1;
      regRd    <= 1'b0;
   endtask

   // One idle cycle on the bus
   task automatic idle();
      @(posedge core_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
   endtask

   // Read and compare the data standing in the following cycle
   task automatic rdChk(input logic [3:0] addr, input logic [7:0] exp);
      @(posedge core_clk);
      regAddr <= addr;
      regRd   <= 1'b1;
      regWr   <= 1'b0;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(negedge core_clk);
      chk({8'h00, regRdata}, {8'h00, exp});
   endtask

   // Follow the enable pulses until the new code is in force, then time two periods
   task automatic waitSwitch(input logic [3:0] code);
      int   newP;
      int   last;
      int   seen;
      int   per;
      logic sw;
      newP = 1 << ((code > 4'h8) ? 8 : int'(code));
      last = -1;
      seen = 0;
      sw   = 1'b0;
      for (int i = 0; i < 1500 && seen < 2; i++) begin
         @(negedge core_clk);
         if (sysClkEn === 1'b1) begin
            per = i - last;
            if (sw) begin
               seen++;
               chk(16'(per), 16'(newP));
            end else if (last >= 0) begin
               chk(16'(per >= ((newP < curP) ? newP : curP)), 16'h0001);
            end
            if (activeDivCode === code) begin
               sw = 1'b1;
            end
            last = i;
         end
      end
      chk(16'(seen), 16'h0002);
      curP = newP;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hang
   initial begin
      #100000;
      errCount++;
      stopTest();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      // Programmed fuse: start divided by eight
      doReset(1'b1, 8'hA5);
      idle();
      @(negedge core_clk);
      chk({8'h00, oscTrim}, 16'h00A5);
      chk({12'h000, activeDivCode}, 16'h0003);
      rdChk(scprt_pkg::TRIM_OFFSET, 8'hA5);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h03);
      waitSwitch(4'h3);
      // Trim values pass to the oscillator and read back
      foreach (trimVals[i]) begin
         wrReg(scprt_pkg::TRIM_OFFSET, trimVals[i]);
         rdChk(scprt_pkg::TRIM_OFFSET, trimVals[i]);
         chk({8'h00, oscTrim}, {8'h00, trimVals[i]});
         chk({15'h0000, trimRangeSelect}, {15'h0000, trimVals[i][7]});
      end
      // Unmapped place reads zero and leaves trim alone
      wrReg(4'h5, 8'h11);
      rdChk(4'h5, 8'h00);
      rdChk(scprt_pkg::TRIM_OFFSET, 8'hFF);
      // Unlock with other bits set does not open the window
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h81);
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h05);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h03);
      // Second unlock neither clears nor stretches the window
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h80);
      idle();
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h80);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h83);
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h01);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h03);
      // Code write in the last cycle of the window is taken
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h80);
      repeat (3) idle();
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h01);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h01);
      waitSwitch(4'h1);
      // Window closes by itself after four cycles
      wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h80);
      repeat (4) idle();
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h01);
      // Reset again in mid-run with the fuse unprogrammed
      doReset(1'b0, 8'h3C);
      rdChk(scprt_pkg::TRIM_OFFSET, 8'h3C);
      rdChk(scprt_pkg::PRESCALE_OFFSET, 8'h00);
      waitSwitch(4'h0);
      // Codes 0 to 8 and reserved codes 9 and F, unused bits set in the data
      foreach (codes[i]) begin
         wrReg(scprt_pkg::PRESCALE_OFFSET, 8'h80);
         wrReg(scprt_pkg::PRESCALE_OFFSET, {4'h7, codes[i]});
         rdChk(scprt_pkg::PRESCALE_OFFSET, {4'h0, codes[i]});
         waitSwitch(codes[i]);
      end
      stopTest();
   end
endmodule
